// file: core/aacr_pkg.sv
package aacr_pkg;
  // Register addresses
  localparam logic [6:0] ADR_IDENT  = 7'h00;
  localparam logic [6:0] ADR_GLOBAL = 7'h01;
  localparam logic [6:0] ADR_OVF    = 7'h02;
  localparam logic [6:0] ADR_MASK   = 7'h03;
  localparam logic [6:0] ADR_HPF    = 7'h04;
  localparam logic [6:0] ADR_PDN    = 7'h06;
  localparam logic [6:0] ADR_MUTE   = 7'h08;
  localparam logic [6:0] ADR_OUTPUT_ENABLE_REGISTER   = 7'h0a;
  localparam logic [6:0] ADR_LAST   = 7'h0a;

  // Pointer byte layout
  localparam int MAP_POINTER_AUTO_INCREMENT_BIT = 7;

  // Global control field positions
  localparam int GC_CPEN    = 7;
  localparam int GC_CLOCK_RATIO_SELECT = 6;
  localparam int GC_MDIV_LO = 4;
  localparam int GC_DIF_LO  = 2;
  localparam int GC_MODE_LO = 0;

  // Power-down field positions
  localparam int PD_BG      = 5;
  localparam int PD_OSC     = 4;
  localparam int PD_PAIR_LO = 0;

  // Channel counts
  localparam int NUM_CH   = 4;
  localparam int NUM_PAIR = 2;

  // Reset values
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_OVF    = 8'hff;
  localparam logic [7:0] RST_MASK   = 8'hff;
  localparam logic [7:0] RST_HPF    = 8'h00;
  localparam logic [7:0] RST_PDN    = 8'h00;
  localparam logic [7:0] RST_MUTE   = 8'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLE_REGISTER   = 8'h00;

  // Writable bits per register
  localparam logic [7:0] WM_CHAN = 8'h0f;
  localparam logic [7:0] WM_PDN  = 8'h33;
  localparam logic [7:0] WM_OUTPUT_ENABLE_REGISTER = 8'h03;

  typedef enum logic [1:0] {
    FMT_LEFT, FMT_I2S, FMT_TDM, FMT_RSVD
  } aacr_fmt_e;

  typedef enum logic [1:0] {
    SPD_SINGLE_MST, SPD_DOUBLE_MST, SPD_QUAD_MST, SPD_SLAVE
  } aacr_speed_e;

  typedef enum logic [2:0] {
    DIV_BY1, DIV_BY1P5, DIV_BY2, DIV_BY3, DIV_BY4, DIV_RSVD
  } aacr_div_e;

  // Host access strobes from the control port engine
  typedef struct packed {
    logic       mapWr;
    logic       dataWr;
    logic       dataRd;
    logic [7:0] wdata;
  } aacr_req_s;

  // Stand-alone strap pins, same order as global bits 6:0
  typedef struct packed {
    logic       clkRatio;
    logic [1:0] mdiv;
    logic [1:0] fmt;
    logic [1:0] mode;
  } aacr_pins_s;

  // Effective configuration to the datapath
  typedef struct packed {
    aacr_fmt_e             fmt;
    aacr_speed_e           speed;
    aacr_div_e             div;
    logic [NUM_CH-1:0]     hpfFreeze;
    logic                  bgDown;
    logic                  oscStop;
    logic [NUM_PAIR-1:0]   pairGate;
    logic [NUM_CH-1:0]     chanZero;
    logic [NUM_PAIR-1:0]   sdoutOe;
  } aacr_cfg_s;

  localparam aacr_cfg_s CFG_RST = '{FMT_LEFT, SPD_SINGLE_MST, DIV_BY1,
                                    4'h0, 1'b0, 1'b0, 2'h0, 4'h0, 2'h0};
endpackage

// file: core/aacr_sync.sv
`timescale 1ns/1ps
module aacr_sync import aacr_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] stable
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // Accept a bit only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // Three-stage chain, first stage read only by the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= async;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign stable = out_ff;
endmodule

// file: core/aacr_sticky.sv
`timescale 1ns/1ps
module aacr_sticky import aacr_pkg::*; #(
  parameter int W = NUM_CH
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] event_i,
  input  wire logic         clear,
  output logic      [W-1:0] flagN
);
  logic [W-1:0] flag_ff;
  logic [W-1:0] nxt_flag;

  // Low means overflow seen; a new event beats the clear
  always_comb begin
    nxt_flag = (clear ? {W{1'b1}} : flag_ff) & ~event_i;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= {W{1'b1}};
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flagN = flag_ff;
endmodule

// file: core/aacr_regs.sv
`timescale 1ns/1ps
module aacr_regs import aacr_pkg::*; #(
  parameter logic [3:0] PART_ID  = 4'h9, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h2  // Arbitrary value
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire aacr_req_s         req,
  input  wire logic [NUM_CH-1:0] ovfEvent,
  input  wire aacr_pins_s        pins,
  output logic      [7:0]        rdData,
  output logic                   rdValid,
  output logic      [7:0]        mapPtr,
  output aacr_cfg_s              cfg,
  output logic                   ovfPinOe
);
  logic [6:0]          ptr_ff;
  logic                pointer_auto_increment_ff;
  logic [6:0]          nxt_ptr;
  logic                nxt_pointer_auto_increment;
  logic [7:0]          glob_ff;
  logic [7:0]          mask_ff;
  logic [7:0]          hpf_ff;
  logic [7:0]          pdn_ff;
  logic [7:0]          mute_ff;
  logic [7:0]          output_enable_register_ff;
  logic [7:0]          nxt_glob;
  logic [7:0]          nxt_mask;
  logic [7:0]          nxt_hpf;
  logic [7:0]          nxt_pdn;
  logic [7:0]          nxt_mute;
  logic [7:0]          nxt_output_enable_register;
  logic [7:0]          rdData_ff;
  logic                rdValid_ff;
  logic [7:0]          nxt_rdData;
  logic                nxt_rdValid;
  aacr_cfg_s           cfg_ff;
  aacr_cfg_s           nxt_cfg;
  logic                ovfOe_ff;
  logic                nxt_ovfOe;
  logic [NUM_CH-1:0]   ovfFlagN;
  logic                ovfClr;
  logic                cpEn;
  logic                access;
  aacr_pins_s          pinsStable;

  // Strap pins arrive from outside the clock domain
  aacr_sync #(
    .W ($bits(aacr_pins_s))
  ) u_pinSync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .async  (pins),
    .stable (pinsStable)
  );

  // Status clears on a host read of its address
  assign ovfClr = req.dataRd && !req.mapWr && ptr_ff == ADR_OVF;

  aacr_sticky #(
    .W (NUM_CH)
  ) u_ovfFlags (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .event_i (ovfEvent),
    .clear   (ovfClr),
    .flagN   (ovfFlagN)
  );

  assign cpEn   = glob_ff[GC_CPEN];
  assign access = (req.dataRd || req.dataWr) && !req.mapWr;

  function automatic aacr_div_e divDecode(input logic [2:0] sel);
    case (sel)
      3'h0:       divDecode = DIV_BY1;
      3'h4:       divDecode = DIV_BY1P5;
      3'h1, 3'h2: divDecode = DIV_BY2;
      3'h5, 3'h6: divDecode = DIV_BY3;
      3'h3:       divDecode = DIV_BY4;
      default:    divDecode = DIV_RSVD;
    endcase
  endfunction

  // Address pointer: loaded by pointer byte, steps on data bytes when auto-increment is set
  always_comb begin
    nxt_ptr  = ptr_ff;
    nxt_pointer_auto_increment = pointer_auto_increment_ff;
    if (req.mapWr) begin
      nxt_ptr  = req.wdata[6:0];
      nxt_pointer_auto_increment = req.wdata[MAP_POINTER_AUTO_INCREMENT_BIT];
    end else if (access && pointer_auto_increment_ff) begin
      nxt_ptr = ptr_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff  <= 7'h00;
      pointer_auto_increment_ff <= 1'b0;
    end else begin
      ptr_ff  <= nxt_ptr;
      pointer_auto_increment_ff <= nxt_pointer_auto_increment;
    end
  end

  // Writable registers; identity and status ignore writes
  always_comb begin
    nxt_glob = glob_ff;
    nxt_mask = mask_ff;
    nxt_hpf  = hpf_ff;
    nxt_pdn  = pdn_ff;
    nxt_mute = mute_ff;
    nxt_output_enable_register = output_enable_register_ff;
    if (req.dataWr && !req.mapWr) begin
      case (ptr_ff)
        ADR_GLOBAL: nxt_glob = req.wdata;
        ADR_MASK:   nxt_mask = req.wdata | ~WM_CHAN;
        ADR_HPF:    nxt_hpf  = req.wdata & WM_CHAN;
        ADR_PDN:    nxt_pdn  = req.wdata & WM_PDN;
        ADR_MUTE:   nxt_mute = req.wdata & WM_CHAN;
        ADR_OUTPUT_ENABLE_REGISTER:   nxt_output_enable_register = req.wdata & WM_OUTPUT_ENABLE_REGISTER;
        default:    nxt_glob = glob_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      glob_ff <= RST_GLOBAL;
      mask_ff <= RST_MASK;
      hpf_ff  <= RST_HPF;
      pdn_ff  <= RST_PDN;
      mute_ff <= RST_MUTE;
      output_enable_register_ff <= RST_OUTPUT_ENABLE_REGISTER;
    end else begin
      glob_ff <= nxt_glob;
      mask_ff <= nxt_mask;
      hpf_ff  <= nxt_hpf;
      pdn_ff  <= nxt_pdn;
      mute_ff <= nxt_mute;
      output_enable_register_ff <= nxt_output_enable_register;
    end
  end

  // Read data; unused status and mask bits read high as at reset
  always_comb begin
    nxt_rdValid = req.dataRd && !req.mapWr;
    nxt_rdData  = rdData_ff;
    if (nxt_rdValid) begin
      case (ptr_ff)
        ADR_IDENT:  nxt_rdData = {PART_ID, REVISION};
        ADR_GLOBAL: nxt_rdData = glob_ff;
        ADR_OVF:    nxt_rdData = {4'hf, ovfFlagN};
        ADR_MASK:   nxt_rdData = mask_ff;
        ADR_HPF:    nxt_rdData = hpf_ff;
        ADR_PDN:    nxt_rdData = pdn_ff;
        ADR_MUTE:   nxt_rdData = mute_ff;
        ADR_OUTPUT_ENABLE_REGISTER:   nxt_rdData = output_enable_register_ff;
        default:    nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff  <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  // Effective configuration: pins until control port is enabled.
  // Stand-alone keeps filters on, nothing muted or powered down.
  always_comb begin
    logic [7:0] effGlob;
    effGlob = cpEn ? glob_ff : {1'b0, pinsStable};
    nxt_cfg = CFG_RST;
    nxt_cfg.fmt   = aacr_fmt_e'(effGlob[GC_DIF_LO +: 2]);
    nxt_cfg.speed = aacr_speed_e'(effGlob[GC_MODE_LO +: 2]);
    nxt_cfg.div   = divDecode({effGlob[GC_CLOCK_RATIO_SELECT],
                               effGlob[GC_MDIV_LO +: 2]});
    nxt_cfg.sdoutOe = {NUM_PAIR{1'b1}};
    if (cpEn) begin
      nxt_cfg.hpfFreeze = hpf_ff[NUM_CH-1:0];
      nxt_cfg.bgDown    = pdn_ff[PD_BG];
      nxt_cfg.oscStop   = pdn_ff[PD_OSC];
      nxt_cfg.pairGate  = pdn_ff[PD_PAIR_LO +: NUM_PAIR];
      for (int c = 0; c < NUM_CH; c++) begin
        nxt_cfg.chanZero[c] = mute_ff[c]
                            | pdn_ff[PD_PAIR_LO + c / 2];
      end
      nxt_cfg.sdoutOe = ~output_enable_register_ff[NUM_PAIR-1:0];
    end
  end

  // Open-drain pin pulls low on any unmasked sticky overflow
  always_comb begin
    logic [NUM_CH-1:0] effMask;
    effMask   = cpEn ? mask_ff[NUM_CH-1:0] : {NUM_CH{1'b1}};
    nxt_ovfOe = |(~ovfFlagN & effMask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= CFG_RST;
      ovfOe_ff <= 1'b0;
    end else begin
      cfg_ff   <= nxt_cfg;
      ovfOe_ff <= nxt_ovfOe;
    end
  end

  assign rdData   = rdData_ff;
  assign rdValid  = rdValid_ff;
  assign mapPtr   = {pointer_auto_increment_ff, ptr_ff};
  assign cfg      = cfg_ff;
  assign ovfPinOe = ovfOe_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence idRead;
    req.dataRd && !req.mapWr && ptr_ff == ADR_IDENT;
  endsequence

  sequence rsvdRead;
    req.dataRd && !req.mapWr && ptr_ff > ADR_LAST;
  endsequence

  sequence ovfSeen;
    |ovfEvent;
  endsequence

  sequence unmaskedOvf;
    |(~ovfFlagN & mask_ff[NUM_CH-1:0]) && cpEn;
  endsequence

  id_read_only_a : assert property (
    idRead |=> rdValid && rdData == {PART_ID, REVISION})
    else $error("identity read returned wrong value");

  rsvd_addr_zero_a : assert property (
    rsvdRead |=> rdValid && rdData == 8'h00)
    else $error("reserved address did not read zero");

  pins_standalone_a : assert property (
    !cpEn |=> cfg.fmt == aacr_fmt_e'($past(pinsStable.fmt)))
    else $error("stand-alone format not taken from pins");

  div_by_4_a : assert property (
    cpEn && glob_ff[6:4] == 3'h3 |=> cfg.div == DIV_BY4)
    else $error("divider code 011 not divide by four");

  div_by_1p5_a : assert property (
    cpEn && glob_ff[6:4] == 3'h4 |=> cfg.div == DIV_BY1P5)
    else $error("ratio bit alone not divide by 1.5");

  mode_decode_a : assert property (
    cpEn && glob_ff[1:0] == 2'h3 |=> cfg.speed == SPD_SLAVE)
    else $error("mode 3 not decoded as slave");

  set_wins_a : assert property (
    ovfSeen |=> (ovfFlagN & $past(ovfEvent)) == '0)
    else $error("overflow event did not drive flag low");

  sticky_hold_a : assert property (
    !ovfClr |=> (ovfFlagN & ~$past(ovfFlagN)) == '0)
    else $error("overflow flag rose without status read");

  clear_read_a : assert property (
    ovfClr && ovfEvent == '0 |=> ovfFlagN == {NUM_CH{1'b1}})
    else $error("status read did not clear flags");

  pin_pull_a : assert property (
    unmaskedOvf |=> ovfPinOe)
    else $error("unmasked overflow did not pull pin");

  mute_zero_a : assert property (
    cpEn && mute_ff[0] |=> cfg.chanZero[0])
    else $error("muted channel not forced to zero");

  serial_audio_output_float_a : assert property (
    cpEn && output_enable_register_ff[1] |=> !cfg.sdoutOe[1])
    else $error("tristate bit did not float output");

  ptr_step_a : assert property (
    access && pointer_auto_increment_ff |=> ptr_ff == $past(ptr_ff) + 7'h01)
    else $error("pointer did not advance");

  ptr_hold_a : assert property (
    access && !pointer_auto_increment_ff ##1 !req.mapWr |-> $stable(ptr_ff))
    else $error("pointer moved with increment off");
endmodule

// file: tb/aacr_host.sv
`timescale 1ns/1ps
// Host side of the control port, reduced to byte strobes
module aacr_host import aacr_pkg::*; (
  input  wire logic       mclk,
  output aacr_req_s       req,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  initial req = '0;
  // Pointer byte, bit 7 asks for auto-increment
  task automatic setPtr(input logic [7:0] p);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, 1'b0, p};
  endtask
  // Strobe left up; the next task overrides it at the next edge
  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, 1'b0, d};
  endtask
  // Read strobe held for exactly the edge that takes it
  task automatic rd(output logic [7:0] d, output logic v);
    @(posedge mclk);
    req <= '{1'b0, 1'b0, 1'b1, 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    d = rdData;
    v = rdValid;
  endtask
  task automatic idle();
    @(posedge mclk);
    req <= '0;
  endtask
endmodule

// file: tb/test_audio_adc_control_registers.sv
`timescale 1ns/1ps
module test_audio_adc_control_registers import aacr_pkg::*;;
  localparam logic [3:0] PID = 4'h9; // Arbitrary value
  localparam logic [3:0] REV = 4'h2; // Arbitrary value
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  aacr_req_s         req;
  logic [NUM_CH-1:0] ovfEvent = '0;
  aacr_pins_s        pins = 7'h59;
  logic [7:0]        rdData;
  logic              rdValid;
  logic [7:0]        mapPtr;
  aacr_cfg_s         cfg;
  logic              ovfPinOe;
  int                n_fail = 0;
  int                tests_run = 0;
  // Write image and expected readback, addresses 0x00 to 0x0b
  logic [7:0] wTab [12] = '{8'h55, 8'h00, 8'h00, 8'hfa, 8'hff, 8'hff,
                            8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rTab [12] = '{{PID, REV}, 8'h00, 8'hff, 8'hfa, 8'h0f,
                            8'h00, 8'h33, 8'h00, 8'h0f, 8'h00, 8'h03,
                            8'h00};
  aacr_div_e  divTab [8] = '{DIV_BY1, DIV_BY2, DIV_BY2, DIV_BY4,
                             DIV_BY1P5, DIV_BY3, DIV_BY3, DIV_RSVD};

  always #5 mclk = ~mclk;

  aacr_regs #(.PART_ID(PID), .REVISION(REV)) dut (
    .mclk(mclk), .rst_n(rst_n), .req(req), .ovfEvent(ovfEvent),
    .pins(pins), .rdData(rdData), .rdValid(rdValid), .mapPtr(mapPtr),
    .cfg(cfg), .ovfPinOe(ovfPinOe));

  aacr_host host (
    .mclk(mclk), .req(req), .rdData(rdData), .rdValid(rdValid));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(d, v);
    chk(v, 1'b1);
    chk(d, exp);
  endtask

  // Settle one extra step so edge updates have landed
  task automatic waitN(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(input logic [3:0] c);
    @(posedge mclk);
    ovfEvent <= c;
    @(posedge mclk);
    ovfEvent <= '0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the roughly 170 cycles of the run
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // Stand-alone straps reach cfg through the synchroniser
    waitN(6);
    chk(cfg.fmt, FMT_TDM);
    chk(cfg.speed, SPD_DOUBLE_MST);
    chk(cfg.div, DIV_BY3);
    host.setPtr(8'h80);
    for (int a = 0; a < 12; a++) begin
      rdChk(a == 0 ? rTab[0] : (a == 2 || a == 3) ? 8'hff : 8'h00);
    end
    chk(mapPtr, 8'h8c);
    $display("reset values done");
    // Write every slot, reserved and read-only included
    host.setPtr(8'h80);
    for (int a = 0; a < 12; a++) host.wr(wTab[a]);
    host.setPtr(8'h80);
    for (int a = 0; a < 12; a++) rdChk(rTab[a]);
    chk(cfg.chanZero, 4'h0);
    chk(cfg.sdoutOe, 2'h3);
    chk(cfg.hpfFreeze, 4'h0);
    $display("write readback done");
    // Control port on, every divider, format and mode code
    for (int k = 0; k < 8; k++) begin
      host.setPtr(8'h01);
      host.wr(8'h80 | 8'(k << 4) | 8'((k & 3) << 2) | 8'(k & 3));
      host.idle();
      waitN(2);
      chk(cfg.div, divTab[k]);
      chk(cfg.fmt, k & 3);
      chk(cfg.speed, k & 3);
    end
    chk(cfg.hpfFreeze, 4'hf);
    chk(cfg.bgDown, 1'b1);
    chk(cfg.oscStop, 1'b1);
    chk(cfg.pairGate, 2'h3);
    chk(cfg.chanZero, 4'hf);
    chk(cfg.sdoutOe, 2'h0);
    $display("global modes done");
    // Pair one down alone, then two writes at a fixed pointer
    host.setPtr(8'h06);
    host.wr(8'h01);
    host.setPtr(8'h08);
    host.wr(8'h05);
    host.wr(8'h04);
    host.idle();
    rdChk(8'h04);
    chk(mapPtr, 8'h08);
    waitN(1);
    chk(cfg.pairGate, 2'h1);
    chk(cfg.chanZero, 4'h7);
    $display("fixed pointer done");
    // Channel 1 masked, channel 2 drives the pin
    pulse(4'h1);
    waitN(4);
    chk(ovfPinOe, 1'b0);
    host.setPtr(8'h02);
    rdChk(8'hfe);
    rdChk(8'hff);
    pulse(4'h2);
    waitN(5);
    chk(ovfPinOe, 1'b1);
    host.setPtr(8'h02);
    rdChk(8'hfd);
    waitN(2);
    chk(ovfPinOe, 1'b0);
    // Channels 3 and 4 together; only channel 4 is unmasked
    pulse(4'hc);
    waitN(4);
    chk(ovfPinOe, 1'b1);
    $display("overflow done");
    // Reset in mid-run with flags still low and new straps
    @(posedge mclk);
    rst_n <= 1'b0;
    pins  <= 7'h26;
    #1;
    chk(ovfPinOe, 1'b0);
    chk(cfg, CFG_RST);
    chk(mapPtr, 8'h00);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    waitN(6);
    chk(cfg.fmt, FMT_I2S);
    chk(cfg.speed, SPD_QUAD_MST);
    chk(cfg.div, DIV_BY2);
    host.setPtr(8'h81);
    rdChk(8'h00);
    rdChk(8'hff);
    rdChk(8'hff);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
